// ===== hps_defs.svh
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH
`define HPS_I2C_ADDR     7'h43
`define HPS_A_FLOOR      8'h08
`define HPS_A_SHDN       8'h0A
`define HPS_A_BOOT       8'h0C
`define HPS_A_EXT        8'h0E
`define HPS_A_TRIM       8'h10
`define HPS_A_DELAY      8'h12
`define HPS_A_POLICY     8'h14
`define HPS_A_WAKE       8'h16
`define HPS_A_ALIVE      8'h18
`define HPS_A_VBAT       8'h19
`define HPS_A_SUPPLY_OUTPUT_LEVEL       8'h1B
`define HPS_RST_FLOOR    16'h0248
`define HPS_RST_SHDN     16'h025C
`define HPS_RST_BOOT     16'h0285
`define HPS_RST_EXT      16'h02CD
`define HPS_RST_TRIM     16'h0000
`define HPS_RST_DELAY    16'h0041
`define HPS_RST_POLICY   8'h00
`define HPS_RST_WAKE     16'h0000
`define HPS_POL_TOUCH    8'h00
`define HPS_POL_VBAT     8'h01
`define HPS_POL_SMART    8'h02
`define HPS_MINUTE_S     32'h0000_003C
`define HPS_CLK_HZ       32'h017D_7840
`endif

// ===== hps_host.sv
`timescale 1ns/10ps
`include "hps_defs.svh"
module hps_host (
  input  wire logic clk,
  input  wire logic sda_oe_n,
  input  wire logic power_indicator_led,
  output logic      scl,
  output logic      sda,
  output logic      host_tx
);
  logic drv = 1'b1;
  logic tx_up = 1'b1;
  // Pull-up: the line is low if either side pulls
  assign sda = drv & sda_oe_n;
  // An unpowered host leaves its transmit pin low
  assign host_tx = power_indicator_led & tx_up;
  initial scl = 1'b1;
  always @(posedge clk) begin
    if (!power_indicator_led) tx_up <= 1'b1;
  end
  task automatic halt();
    tx_up = 1'b0;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    drv = b;
    w(4);
    scl = 1'b1;
    w(4);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    drv = 1'b1;
    w(4);
    scl = 1'b1;
    w(4);
    drv = 1'b0;
    w(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    w(4);
    scl = 1'b1;
    w(4);
    drv = 1'b1;
    w(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xfer({`HPS_I2C_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic       a;
    start();
    xfer({`HPS_I2C_ADDR, 1'b0}, 1'b1, q, a);
    xfer(p, 1'b1, q, a);
    start();
    xfer({`HPS_I2C_ADDR, 1'b1}, 1'b1, q, a);
    // Single byte, so the last bit is a refusal to continue
    xfer(8'hFF, 1'b1, d, a);
    stop();
  endtask
endmodule // hps_host

// ===== hps_i2c_target.sv
`timescale 1ns/10ps
`include "hps_defs.svh"
module hps_i2c_target (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_oe_n,
  hps_bus_if.target bus
);
  import hps_pkg::*;

  hps_i2c_t   st_q, st_d;
  logic       scl_q, sda_q;
  logic [7:0] sr_q, sr_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d, first_q, first_d;
  logic       oe_n_q, oe_n_d, wr_q, wr_d;
  logic       rise, fall, start, stop;

  assign rise  = scl & ~scl_q;
  assign fall  = ~scl & scl_q;
  assign start = scl & scl_q & sda_q & ~sda_in;
  assign stop  = scl & scl_q & ~sda_q & sda_in;

  always_comb begin
    st_d    = st_q;
    sr_d    = sr_q;
    ptr_d   = wr_q ? ptr_q + 8'h01 : ptr_q;
    cnt_d   = cnt_q;
    rw_d    = rw_q;
    first_d = first_q;
    oe_n_d  = oe_n_q;
    wr_d    = 1'b0;
    if (start) begin
      st_d    = I2C_ADDR;
      cnt_d   = 4'h0;
      first_d = 1'b1;
      oe_n_d  = 1'b1;
    end else if (stop) begin
      st_d   = I2C_IDLE;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        I2C_IDLE: ;
        I2C_ADDR, I2C_WR: begin
          if (rise && cnt_q < 4'h8) begin
            sr_d  = {sr_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (st_q == I2C_WR) begin
              oe_n_d = 1'b0;
              st_d   = I2C_ACK_W;
            end else if (sr_q[7:1] == `HPS_I2C_ADDR) begin
              oe_n_d = 1'b0;
              rw_d   = sr_q[0];
              st_d   = I2C_ACK_A;
            end else begin
              st_d = I2C_IDLE;
            end
          end
        end
        I2C_ACK_A: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              sr_d   = bus.rdata;
              oe_n_d = bus.rdata[7];
              st_d   = I2C_RD;
            end else begin
              oe_n_d = 1'b1;
              st_d   = I2C_WR;
            end
          end
        end
        I2C_ACK_W: begin
          if (fall) begin
            oe_n_d = 1'b1;
            cnt_d  = 4'h0;
            st_d   = I2C_WR;
            // First byte after address sets the register pointer
            if (first_q) begin
              ptr_d   = sr_q;
              first_d = 1'b0;
            end else begin
              wr_d = 1'b1;
            end
          end
        end
        I2C_RD: begin
          if (fall) begin
            if (cnt_q == 4'h7) begin
              oe_n_d = 1'b1;
              ptr_d  = ptr_q + 8'h01;
              st_d   = I2C_ACK_R;
            end else begin
              cnt_d  = cnt_q + 4'h1;
              sr_d   = {sr_q[6:0], 1'b0};
              oe_n_d = sr_q[6];
            end
          end
        end
        I2C_ACK_R: begin
          if (rise && sda_in) begin
            st_d = I2C_IDLE;
          end else if (fall) begin
            sr_d   = bus.rdata;
            oe_n_d = bus.rdata[7];
            cnt_d  = 4'h0;
            st_d   = I2C_RD;
          end
        end
        default: begin
          st_d   = I2C_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= I2C_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      sr_q    <= 8'h00;
      ptr_q   <= 8'h00;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      oe_n_q  <= 1'b1;
      wr_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      scl_q   <= scl;
      sda_q   <= sda_in;
      sr_q    <= sr_d;
      ptr_q   <= ptr_d;
      cnt_q   <= cnt_d;
      rw_q    <= rw_d;
      first_q <= first_d;
      oe_n_q  <= oe_n_d;
      wr_q    <= wr_d;
    end
  end

  assign sda_oe_n  = oe_n_q;
  assign bus.wr    = wr_q;
  assign bus.addr  = ptr_q;
  assign bus.wdata = sr_q;
endmodule // hps_i2c_target

// ===== hps_if.sv
`timescale 1ns/10ps
interface hps_bus_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport target (output wr, addr, wdata, input rdata);
  modport regs   (input wr, addr, wdata, output rdata);
endinterface

interface hps_meas_if;
  logic [9:0]  vbat;
  logic [9:0]  supply_output_level;
  logic        fresh;
  logic [15:0] trim;
  modport meas (output vbat, supply_output_level, fresh, input trim);
  modport core (input vbat, supply_output_level, fresh, output trim);
endinterface

// ===== hps_meas.sv
`timescale 1ns/10ps
`include "hps_defs.svh"
module hps_meas (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire hps_pkg::hps_level_t adc_vbat,
  input  wire hps_pkg::hps_level_t adc_supply_output_level,
  input  wire logic               adc_valid,
  hps_meas_if.meas                m
);
  import hps_pkg::*;

  hps_level_t vbat_q, vbat_d, supply_output_level_q, supply_output_level_d;
  logic       fresh_q, fresh_d;

  // Signed trim, clamped to the 10-bit range
  function automatic hps_level_t trimmed(input hps_level_t raw,
                                         input logic [15:0] trim);
    logic signed [17:0] s;
    s = $signed({8'h00, raw}) + $signed({trim[15], trim[15], trim});
    if (s < 0) trimmed = 10'h000;
    else if (s > 18'sh0_03FF) trimmed = 10'h3FF;
    else trimmed = s[9:0];
  endfunction

  always_comb begin
    vbat_d  = vbat_q;
    supply_output_level_d  = supply_output_level_q;
    fresh_d = adc_valid;
    if (adc_valid) begin
      vbat_d = trimmed(adc_vbat, m.trim);
      supply_output_level_d = trimmed(adc_supply_output_level, m.trim);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vbat_q  <= 10'h000;
      supply_output_level_q  <= 10'h000;
      fresh_q <= 1'b0;
    end else begin
      vbat_q  <= vbat_d;
      supply_output_level_q  <= supply_output_level_d;
      fresh_q <= fresh_d;
    end
  end

  assign m.vbat  = vbat_q;
  assign m.supply_output_level  = supply_output_level_q;
  assign m.fresh = fresh_q;
endmodule // hps_meas

// ===== hps_pkg.sv
package hps_pkg;
  typedef logic [9:0] hps_level_t;
  typedef enum logic [4:0] {
    PWR_OFF  = 5'h01,
    PWR_BOOT = 5'h02,
    PWR_RUN  = 5'h04,
    PWR_WAIT = 5'h08,
    PWR_DLY  = 5'h10
  } hps_pwr_t;
  typedef enum logic [6:0] {
    I2C_IDLE  = 7'h01,
    I2C_ADDR  = 7'h02,
    I2C_ACK_A = 7'h04,
    I2C_WR    = 7'h08,
    I2C_ACK_W = 7'h10,
    I2C_RD    = 7'h20,
    I2C_ACK_R = 7'h40
  } hps_i2c_t;
endpackage

// ===== hps_top.sv
`timescale 1ns/10ps
`include "hps_defs.svh"
module hps_top #(
  parameter int unsigned MINUTE_CYCLES = `HPS_MINUTE_S * `HPS_CLK_HZ
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                SCL,
  input  wire logic                SDA_IN,
  output logic                     SDA_OUT,
  output logic                     SDA_OE_N,
  input  wire hps_pkg::hps_level_t ADC_VBAT,
  input  wire hps_pkg::hps_level_t ADC_SUPPLY_OUTPUT_LEVEL,
  input  wire logic                ADC_VALID,
  input  wire logic                TOUCH_ON,
  input  wire logic                TOUCH_OFF,
  input  wire logic                SYS_TICK,
  input  wire logic                HOST_TX,
  output logic                     HOST_POWER_EN,
  output logic                     POWER_INDICATOR_LED
);
  import hps_pkg::*;

  localparam logic [15:0] CFG_RST [6] = '{`HPS_RST_FLOOR, `HPS_RST_SHDN,
    `HPS_RST_BOOT, `HPS_RST_EXT, `HPS_RST_TRIM, `HPS_RST_DELAY};
  localparam logic [30:0] MIN_LAST = 31'(MINUTE_CYCLES - 1);

  hps_bus_if  bus ();
  hps_meas_if m ();

  hps_i2c_target u_i2c (
    .clk      (CLK),
    .rst_n    (RST_N),
    .scl      (SCL),
    .sda_in   (SDA_IN),
    .sda_oe_n (SDA_OE_N),
    .bus      (bus.target)
  );

  hps_meas u_meas (
    .clk       (CLK),
    .rst_n     (RST_N),
    .adc_vbat  (ADC_VBAT),
    .adc_supply_output_level  (ADC_SUPPLY_OUTPUT_LEVEL),
    .adc_valid (ADC_VALID),
    .m         (m.meas)
  );

  // Config words 0..5 sit at byte pairs from the floor level upward
  logic [15:0] cfg_q [6];
  logic [15:0] cfg_d [6];
  logic [7:0]  policy_q, policy_d;
  logic [15:0] wake_q, wake_d, dly_q, dly_d;
  logic [30:0] min_q, min_d;
  hps_pwr_t    st_q, st_d;
  logic        alive_q, alive_d, power_q, power_d;
  logic        led_q, led_d, lowv_q, lowv_d;
  logic [15:0] vb16, vo16;
  logic [2:0]  idx;
  logic        in_cfg, floor_hit, shdn_hit, boot_ok, ext_on;
  logic        min_tick, wake_fire, want_boot, alive_wr;
  logic [7:0]  rd;

  function automatic logic [7:0] byte_of(input logic [15:0] v,
                                         input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  // Write strobe aimed at one byte address
  function automatic logic reg_hit(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] at);
    reg_hit = wr && addr == at;
  endfunction

  assign vb16      = {6'h00, m.vbat};
  assign vo16      = {6'h00, m.supply_output_level};
  assign in_cfg    = bus.addr >= `HPS_A_FLOOR && bus.addr < `HPS_A_POLICY;
  assign idx       = 3'((bus.addr - `HPS_A_FLOOR) >> 1);
  assign floor_hit = vb16 < cfg_q[0];
  assign shdn_hit  = vb16 < cfg_q[1];
  assign boot_ok   = vb16 >= cfg_q[2];
  assign ext_on    = vo16 >= cfg_q[3];
  assign alive_wr  = reg_hit(bus.wr, bus.addr, `HPS_A_ALIVE);
  assign min_tick  = min_q == MIN_LAST;
  assign wake_fire = st_q == PWR_OFF && wake_q == 16'h0001 && min_tick;
  assign m.trim    = cfg_q[4];

  // Policy and wake timer are independent boot causes
  always_comb begin
    want_boot = TOUCH_ON | wake_fire;
    if (policy_q == `HPS_POL_VBAT) want_boot = 1'b1;
    if (policy_q == `HPS_POL_SMART && lowv_q) want_boot = 1'b1;
  end

  // Register read map
  always_comb begin
    rd = 8'h00;
    if (in_cfg) rd = byte_of(cfg_q[idx], bus.addr[0]);
    case (bus.addr)
      `HPS_A_POLICY:         rd = policy_q;
      `HPS_A_WAKE:           rd = wake_q[7:0];
      `HPS_A_WAKE + 8'h01:   rd = wake_q[15:8];
      `HPS_A_ALIVE:          rd = {7'h00, alive_q};
      `HPS_A_VBAT:           rd = byte_of(vb16, 1'b0);
      `HPS_A_VBAT + 8'h01:   rd = byte_of(vb16, 1'b1);
      `HPS_A_SUPPLY_OUTPUT_LEVEL:           rd = byte_of(vo16, 1'b0);
      `HPS_A_SUPPLY_OUTPUT_LEVEL + 8'h01:   rd = byte_of(vo16, 1'b1);
      default: ;
    endcase
  end
  assign bus.rdata = rd;

  // Configuration words, one byte lane per access
  for (genvar g = 0; g < 6; g++) begin : g_cfg
    localparam logic [7:0] LO = 8'(`HPS_A_FLOOR + 2 * g);

    always_comb begin
      cfg_d[g] = cfg_q[g];
      if (reg_hit(bus.wr, bus.addr, LO)) begin
        cfg_d[g][7:0] = bus.wdata;
      end
      if (reg_hit(bus.wr, bus.addr, LO + 8'h01)) begin
        cfg_d[g][15:8] = bus.wdata;
      end
    end

    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        cfg_q[g] <= CFG_RST[g];
      end else begin
        cfg_q[g] <= cfg_d[g];
      end
    end
  end

  always_comb begin
    policy_d = policy_q;
    if (reg_hit(bus.wr, bus.addr, `HPS_A_POLICY)) begin
      policy_d = bus.wdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      policy_q <= `HPS_RST_POLICY;
    end else begin
      policy_q <= policy_d;
    end
  end

  // Prescaler only runs while off and armed, so minutes start at off
  always_comb begin
    wake_d = wake_q;
    min_d  = 31'h0000_0000;
    if (st_q == PWR_OFF && wake_q != 16'h0000) begin
      min_d = min_tick ? 31'h0000_0000 : min_q + 31'h0000_0001;
      if (min_tick) begin
        wake_d = wake_q - 16'h0001;
      end
    end
    // Host write wins over a same-cycle decrement
    if (reg_hit(bus.wr, bus.addr, `HPS_A_WAKE)) begin
      wake_d[7:0] = bus.wdata;
    end
    if (reg_hit(bus.wr, bus.addr, `HPS_A_WAKE + 8'h01)) begin
      wake_d[15:8] = bus.wdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wake_q <= `HPS_RST_WAKE;
      min_q  <= 31'h0000_0000;
    end else begin
      wake_q <= wake_d;
      min_q  <= min_d;
    end
  end

  // Power sequencing and indicator LED
  always_comb begin
    st_d    = st_q;
    power_d = power_q;
    alive_d = alive_q;
    lowv_d  = lowv_q;
    dly_d   = dly_q;
    led_d   = led_q;
    case (st_q)
      PWR_OFF: begin
        alive_d = 1'b0;
        led_d   = 1'b0;
        if (want_boot && boot_ok && !ext_on) begin
          power_d = 1'b1;
          lowv_d  = 1'b0;
          led_d   = 1'b1;
          st_d    = PWR_BOOT;
        end
      end
      PWR_BOOT: begin
        alive_d = 1'b0;
        if (SYS_TICK) led_d = ~led_q;
        if (alive_wr && bus.wdata != 8'h00) begin
          alive_d = 1'b1;
          led_d   = 1'b1;
          st_d    = PWR_RUN;
        end
      end
      PWR_RUN: begin
        led_d = 1'b1;
        if (m.fresh && shdn_hit) begin
          alive_d = 1'b0;
          lowv_d  = 1'b1;
          st_d    = PWR_WAIT;
        end else if (TOUCH_OFF) begin
          alive_d = 1'b0;
          st_d    = PWR_WAIT;
        end else if (alive_wr && bus.wdata == 8'h00) begin
          alive_d = 1'b0;
          st_d    = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        alive_d = 1'b0;
        if (SYS_TICK) led_d = ~led_q;
        if (!HOST_TX) begin
          dly_d = cfg_q[5];
          st_d  = PWR_DLY;
        end
      end
      PWR_DLY: begin
        alive_d = 1'b0;
        if (SYS_TICK) led_d = ~led_q;
        if (dly_q == 16'h0000) begin
          power_d = 1'b0;
          led_d   = 1'b0;
          st_d    = PWR_OFF;
        end else if (SYS_TICK) begin
          dly_d = dly_q - 16'h0001;
        end
      end
      default: begin
        power_d = 1'b0;
        alive_d = 1'b0;
        led_d   = 1'b0;
        st_d    = PWR_OFF;
      end
    endcase
    // Floor cut overrides every other decision in every state but PWR_OFF, no handshake
    if (m.fresh && floor_hit && st_q != PWR_OFF) begin
      power_d = 1'b0;
      alive_d = 1'b0;
      lowv_d  = 1'b1;
      led_d   = 1'b0;
      st_d    = PWR_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dly_q    <= 16'h0000;
      st_q     <= PWR_OFF;
      alive_q  <= 1'b0;
      power_q  <= 1'b0;
      led_q    <= 1'b0;
      lowv_q   <= 1'b0;
    end else begin
      dly_q    <= dly_d;
      st_q     <= st_d;
      alive_q  <= alive_d;
      power_q  <= power_d;
      led_q    <= led_d;
      lowv_q   <= lowv_d;
    end
  end

  // Open-drain: only ever pulls low, enable does the work
  assign SDA_OUT             = 1'b0;
  assign HOST_POWER_EN       = power_q;
  assign POWER_INDICATOR_LED = led_q;
endmodule // hps_top

// ===== hps_top_chk.sv
`timescale 1ns/10ps
module hps_top_chk (
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic                SCL,
  input wire logic                SDA_OUT,
  input wire logic                SDA_OE_N,
  input wire hps_pkg::hps_level_t ADC_VBAT,
  input wire logic                ADC_VALID,
  input wire logic                SYS_TICK,
  input wire logic                HOST_TX,
  input wire logic                HOST_POWER_EN,
  input wire logic                POWER_INDICATOR_LED
);
  import hps_pkg::*;
  logic [2:0] ev_q;
  logic [2:0] ev_d;
  // Recent causes that may legally drop host power
  always_comb begin
    ev_d = {ev_q[1:0], ADC_VALID | SYS_TICK | ~HOST_TX};
  end
  always_ff @(posedge CLK) begin
    ev_q <= ev_d;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_reset_quiet: assert property (disable iff (1'b0)
    !RST_N |=> !HOST_POWER_EN && !POWER_INDICATOR_LED && SDA_OE_N)
    else $error("outputs not idle after reset");
  a_sda_zero: assert property (SDA_OUT == 1'b0)
    else $error("data drive value not zero");
  a_sda_edge: assert property ($changed(SDA_OE_N) |-> !SCL)
    else $error("data line moved while clock high");
  a_ack_hold: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*4])
    else $error("data pull released too soon");
  a_off_cause: assert property ($fell(HOST_POWER_EN) |-> |ev_q)
    else $error("power dropped without cause");
  // Assumes the trim never lifts an empty reading above the floor
  a_floor_cut: assert property (
    ADC_VALID && ADC_VBAT == 10'h000 && HOST_POWER_EN |-> ##2 !HOST_POWER_EN)
    else $error("empty battery did not cut power");
  a_led_dark: assert property (!HOST_POWER_EN |-> !POWER_INDICATOR_LED)
    else $error("indicator lit while host unpowered");
  a_led_tick: assert property (
    $fell(POWER_INDICATOR_LED) && HOST_POWER_EN |-> $past(SYS_TICK))
    else $error("indicator blinked without a tick");
  c_boot: cover property ($rose(HOST_POWER_EN));
  c_cut: cover property ($fell(HOST_POWER_EN));
  c_ack: cover property ($fell(SDA_OE_N));
endmodule // hps_top_chk

bind hps_top hps_top_chk i_hps_top_chk (
  .CLK                 (CLK),
  .RST_N               (RST_N),
  .SCL                 (SCL),
  .SDA_OUT             (SDA_OUT),
  .SDA_OE_N            (SDA_OE_N),
  .ADC_VBAT            (ADC_VBAT),
  .ADC_VALID           (ADC_VALID),
  .SYS_TICK            (SYS_TICK),
  .HOST_TX             (HOST_TX),
  .HOST_POWER_EN       (HOST_POWER_EN),
  .POWER_INDICATOR_LED (POWER_INDICATOR_LED)
);

// ===== hps_top_tb.sv
`timescale 1ns/10ps
`include "hps_defs.svh"
module hps_top_tb;
  import hps_pkg::*;
  localparam logic [7:0] RV [17] = '{8'h48, 8'h02, 8'h5C, 8'h02, 8'h85,
    8'h02, 8'hCD, 8'h02, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       val = 1'b0;
  logic       t_on = 1'b0;
  logic       t_off = 1'b0;
  logic       tick = 1'b0;
  logic       scl, sda, sda_out, oe_n, tx, power_indicator_led, led, ok;
  logic [7:0] r;
  hps_level_t vb = 10'h000;
  hps_level_t vo = 10'h000;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // Short minute keeps the wake timer test inside the run budget
  hps_top #(.MINUTE_CYCLES(400)) i_hps_top (
    .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(oe_n), .ADC_VBAT(vb), .ADC_SUPPLY_OUTPUT_LEVEL(vo), .ADC_VALID(val),
    .TOUCH_ON(t_on), .TOUCH_OFF(t_off), .SYS_TICK(tick), .HOST_TX(tx),
    .HOST_POWER_EN(power_indicator_led), .POWER_INDICATOR_LED(led));
  hps_host i_hps_host (.clk(clk), .sda_oe_n(oe_n), .power_indicator_led(power_indicator_led), .scl(scl),
    .sda(sda), .host_tx(tx));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pw(input logic e);
    chk(16'(power_indicator_led), 16'(e));
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_hps_host.wr(p, d, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    i_hps_host.rd(p, r);
    chk(16'(r), 16'(e));
  endtask
  task automatic smp(input hps_level_t b, input hps_level_t o);
    vb = b;
    vo = o;
    val = 1'b1;
    cy(1);
    val = 1'b0;
    cy(3);
  endtask
  task automatic pulse(input int k);
    {t_off, t_on, tick} = 3'(1 << k);
    cy(1);
    {t_off, t_on, tick} = 3'h0;
    cy(3);
  endtask
  task automatic run();
    rd(`HPS_A_ALIVE, 8'h00);
    wr(`HPS_A_ALIVE, 8'h01);
    rd(`HPS_A_ALIVE, 8'h01);
    chk(16'(led), 16'h0001);
  endtask
  task automatic down(input logic by_host);
    if (by_host) wr(`HPS_A_ALIVE, 8'h00);
    i_hps_host.halt();
    cy(2);
    pulse(0);
    pulse(0);
    pw(1'b1);
    pulse(0);
    pw(1'b0);
  endtask
  initial begin
    cy(20);
    rst_n = 1'b1;
    cy(2);
    for (int i = 0; i < 17; i++) begin
      rd(8'h08 + 8'(i), RV[i]);
    end
    rd(8'h20, 8'h00);
    chk(16'(sda_out), 16'h0000);
    $display("defaults done");
    smp(10'h2BC, 10'h064);
    rd(`HPS_A_VBAT, 8'hBC);
    rd(`HPS_A_VBAT + 8'h01, 8'h02);
    wr(`HPS_A_SUPPLY_OUTPUT_LEVEL, 8'hFF);
    rd(`HPS_A_SUPPLY_OUTPUT_LEVEL, 8'h64);
    rd(`HPS_A_SUPPLY_OUTPUT_LEVEL + 8'h01, 8'h00);
    wr(`HPS_A_TRIM, 8'h05);
    smp(10'h2BC, 10'h064);
    rd(`HPS_A_SUPPLY_OUTPUT_LEVEL, 8'h69);
    wr(`HPS_A_TRIM, 8'h00);
    pw(1'b0);
    $display("measure done");
    wr(`HPS_A_DELAY, 8'h03);
    pulse(1);
    pw(1'b1);
    run();
    pulse(2);
    rd(`HPS_A_ALIVE, 8'h00);
    down(1'b0);
    $display("touch done");
    smp(10'h2BC, 10'h2CD);
    wr(`HPS_A_POLICY, 8'h01);
    pw(1'b0);
    smp(10'h284, 10'h064);
    pw(1'b0);
    smp(10'h285, 10'h2CC);
    pw(1'b1);
    run();
    smp(10'h25B, 10'h064);
    rd(`HPS_A_ALIVE, 8'h00);
    pw(1'b1);
    smp(10'h247, 10'h064);
    pw(1'b0);
    $display("policy one done");
    wr(`HPS_A_POLICY, 8'h02);
    smp(10'h285, 10'h064);
    pw(1'b1);
    smp(10'h000, 10'h064);
    pw(1'b0);
    smp(10'h2BC, 10'h064);
    pw(1'b1);
    pulse(1);
    run();
    down(1'b1);
    smp(10'h2BC, 10'h064);
    pw(1'b0);
    $display("policy two done");
    wr(`HPS_A_POLICY, 8'h00);
    wr(`HPS_A_WAKE, 8'h01);
    for (int i = 0; i < 1000 && power_indicator_led !== 1'b1; i++) begin
      cy(1);
    end
    pw(1'b1);
    rd(`HPS_A_WAKE, 8'h00);
    run();
    down(1'b1);
    wr(`HPS_A_WAKE, 8'h05);
    pulse(1);
    pw(1'b1);
    rd(`HPS_A_WAKE, 8'h05);
    $display("wake done");
    results();
  end
endmodule // hps_top_tb
